// >>> core/cps_core.sv
// Protection state machine with its AXI4-Lite register slave
//
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ns

// Overview of operation
// - No fault: charge and discharge both enabled
// - Overcharge held 130 ms: charge off
// - Below overcharge release: charge back on
// - Discharge start releases overcharge if cell allows
// - No release while overcurrent comparison met
// - High cell inhibits overcurrent, not short
// - Undervoltage held 40 ms: discharge off
// - Pull-up on in overdischarge and power-down
// - Sense above 1.5 V: enter power-down
// - Charger wakes from power-down: charge back on, discharge stays off
// - Cell at detect level: back to normal
// - Without charger, wait for release level
// - Overcurrent 10 ms or short 75 us trips
// - Pull-down on in overcurrent state
// - Sense below overcurrent level: normal again
// - Sense below charger level 130 ms: charge off
// - Abnormal charge timed only after overdischarge ends
// - Abnormal charge clears when charger leaves
// - Zero-volt charging beats abnormal charge detection
// - Over-temperature clears at recovery temperature
// - Short released when sense drops below level
// - Short timing starts at overcurrent detection
// - Still undervoltage after delay: power-down
module cps_core import cps_pkg::*; #(
  parameter logic [CNT_W-1:0] OVERCHG_CYC = OVERCHG_DELAY_CYC,
  parameter logic [CNT_W-1:0] OVERDIS_CYC = OVERDIS_DELAY_CYC,
  parameter logic [CNT_W-1:0] OVERCUR_CYC = OVERCUR_DELAY_CYC,
  parameter logic [CNT_W-1:0] SHORT_CYC = SHORT_DELAY_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Analog comparator results
  input wire cps_cmp_s cmp_in,
  // Switch and sense pin controls
  output logic chg_en,
  output logic dsg_en,
  output logic sense_pullup_en,
  output logic sense_pulldown_en,
  output logic pwrdn_req,
  // AXI4-Lite write channels
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ***************************************************************
  // Comparator synchronisation and delay counters
  // ***************************************************************
  cps_cmp_s cmp;
  cps_core_s cur_reg;
  cps_core_s cur_next;
  logic ovchg_run;
  logic ovchg_done;
  logic ovdis_run;
  logic ovdis_done;
  logic ovcur_run;
  logic ovcur_done;
  logic [CNT_W-1:0] ovcur_count;
  logic abn_run;
  logic abn_done;
  logic iov_hit;
  logic short_hit;

  cps_sync u_sync (
    .clk(clk),
    .rstn(rstn),
    .cmp_async(cmp_in),
    .cmp_sync(cmp)
  );

  // Each delay but the short has its own counter so one qualifier dropping never disturbs another
  assign ovchg_run = (cur_reg.st == ST_NORMAL) && cmp.cell_above_ovchg;
  assign ovdis_run = ((cur_reg.st == ST_NORMAL) || (cur_reg.st == ST_OVERCUR)) && cmp.cell_below_ovdis;
  assign ovcur_run = (cur_reg.st == ST_NORMAL) && cmp.sense_ge_overcur;
  assign abn_run = (cur_reg.st == ST_NORMAL) && cur_reg.drv.dsg_en && cmp.sense_below_charger
                   && !cmp.cell_zero_chg && !cur_reg.abn_chg;

  cps_delay u_ovchg (
    .clk(clk),
    .rstn(rstn),
    .run(ovchg_run),
    .limit(OVERCHG_CYC),
    .done(ovchg_done),
    .count()
  );

  cps_delay u_ovdis (
    .clk(clk),
    .rstn(rstn),
    .run(ovdis_run),
    .limit(OVERDIS_CYC),
    .done(ovdis_done),
    .count()
  );

  cps_delay u_ovcur (
    .clk(clk),
    .rstn(rstn),
    .run(ovcur_run),
    .limit(OVERCUR_CYC),
    .done(ovcur_done),
    .count(ovcur_count)
  );

  cps_delay u_abn (
    .clk(clk),
    .rstn(rstn),
    .run(abn_run),
    .limit(OVERCHG_CYC),
    .done(abn_done),
    .count()
  );

  // Short shares the overcurrent counter, so its delay starts at the first level
  assign short_hit = ovcur_run && cmp.sense_ge_short && (ovcur_count >= SHORT_CYC);
  assign iov_hit = ovcur_done && !cmp.cell_above_ovchg;

  // ***************************************************************
  // Next state
  // ***************************************************************
  always_comb begin
    cur_next = cur_reg;

    // Protection state machine
    unique case (cur_reg.st)
      ST_NORMAL: begin
        if (short_hit || iov_hit) begin
          cur_next.st = ST_OVERCUR;
          cur_next.short_trip = short_hit;
        end else if (ovdis_done) begin
          cur_next.st = ST_OVERDIS;
        end else if (ovchg_done) begin
          cur_next.st = ST_OVERCHG;
        end
      end
      ST_OVERCHG: begin
        if (cmp.cell_below_ovchg_rel) begin
          cur_next.st = ST_NORMAL;
        end else if (cmp.sense_disch_start && !cmp.cell_above_ovchg && !cmp.sense_ge_overcur) begin
          cur_next.st = ST_NORMAL;
        end
      end
      ST_OVERDIS: begin
        if (cmp.sense_above_sleep) begin
          cur_next.st = ST_PWRDN;
        end else if (cmp.sense_below_charger && !cmp.cell_below_ovdis) begin
          cur_next.st = ST_NORMAL;
        end else if (cmp.cell_above_ovdis_rel) begin
          cur_next.st = ST_NORMAL;
        end
      end
      ST_PWRDN: begin
        if (cmp.supply_sense_wake) begin
          cur_next.st = ST_OVERDIS;
        end
      end
      ST_OVERCUR: begin
        if (ovdis_done) begin
          cur_next.st = ST_PWRDN;
          cur_next.short_trip = 1'b0;
        end else if (cur_reg.short_trip ? !cmp.sense_ge_short : !cmp.sense_ge_overcur) begin
          cur_next.st = ST_NORMAL;
          cur_next.short_trip = 1'b0;
        end
      end
      ST_OVERTEMP: begin
        if (cmp.temp_recovered) begin
          cur_next.st = ST_NORMAL;
        end
      end
      default: begin
        cur_next.st = ST_NORMAL;
      end
    endcase

    // Over-temperature outranks every other condition
    if (cmp.temp_trip) begin
      cur_next.st = ST_OVERTEMP;
      cur_next.short_trip = 1'b0;
    end

    // Abnormal charge is a flag beside the state, cleared once the charger goes
    if (abn_done) begin
      cur_next.abn_chg = 1'b1;
    end else if (!cmp.sense_below_charger) begin
      cur_next.abn_chg = 1'b0;
    end

    // AXI4-Lite write: address and data taken in either order, then one response
    if (s_axi_awvalid && s_axi_awready) begin
      cur_next.aw_got = 1'b1;
      cur_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      cur_next.w_got = 1'b1;
      cur_next.w_data = s_axi_wdata;
      cur_next.w_strb = s_axi_wstrb;
    end
    if (cur_reg.aw_got && cur_reg.w_got && !cur_reg.bvalid) begin
      cur_next.aw_got = 1'b0;
      cur_next.w_got = 1'b0;
      cur_next.bvalid = 1'b1;
      if (cur_reg.aw_addr == CTRL_OFFSET) begin
        cur_next.bresp = RESP_OKAY;
        if (cur_reg.w_strb[0]) begin
          cur_next.ctrl = cur_reg.w_data[1:0];
        end
      end else if ((cur_reg.aw_addr == STATUS_OFFSET) || (cur_reg.aw_addr == CMP_OFFSET)) begin
        // Read-only registers ignore the data but answer cleanly
        cur_next.bresp = RESP_OKAY;
      end else begin
        cur_next.bresp = RESP_DECERR;
      end
    end
    if (cur_reg.bvalid && s_axi_bready) begin
      cur_next.bvalid = 1'b0;
    end

    // Drives follow the next state and the next control word, so pins never lag either
    cur_next.drv.chg_en = !(cur_next.st inside {ST_OVERCHG, ST_PWRDN, ST_OVERTEMP})
                          && !cur_next.abn_chg && !cur_next.ctrl[CTRL_CHG_BLOCK_BIT];
    cur_next.drv.dsg_en = !(cur_next.st inside {ST_OVERDIS, ST_PWRDN, ST_OVERCUR, ST_OVERTEMP})
                          && !cur_next.ctrl[CTRL_DSG_BLOCK_BIT];
    cur_next.drv.pullup_en = cur_next.st inside {ST_OVERDIS, ST_PWRDN};
    cur_next.drv.pulldown_en = (cur_next.st == ST_OVERCUR);
    cur_next.drv.pwrdn_req = (cur_next.st == ST_PWRDN);

    // AXI4-Lite read
    if (s_axi_arvalid && s_axi_arready) begin
      cur_next.rvalid = 1'b1;
      cur_next.rresp = RESP_OKAY;
      cur_next.rdata = '0;
      if (s_axi_araddr == CTRL_OFFSET) begin
        cur_next.rdata[1:0] = cur_reg.ctrl;
      end else if (s_axi_araddr == STATUS_OFFSET) begin
        cur_next.rdata[STAT_STATE_LSB +: 3] = cur_reg.st;
        cur_next.rdata[STAT_CHG_EN_BIT] = cur_reg.drv.chg_en;
        cur_next.rdata[STAT_DSG_EN_BIT] = cur_reg.drv.dsg_en;
        cur_next.rdata[STAT_PULLUP_BIT] = cur_reg.drv.pullup_en;
        cur_next.rdata[STAT_PULLDOWN_BIT] = cur_reg.drv.pulldown_en;
        cur_next.rdata[STAT_PWRDN_BIT] = cur_reg.drv.pwrdn_req;
        cur_next.rdata[STAT_ABN_BIT] = cur_reg.abn_chg;
        cur_next.rdata[STAT_SHORT_BIT] = cur_reg.short_trip;
      end else if (s_axi_araddr == CMP_OFFSET) begin
        cur_next.rdata[CMP_W-1:0] = cmp;
      end else begin
        cur_next.rresp = RESP_DECERR;
      end
    end else if (cur_reg.rvalid && s_axi_rready) begin
      cur_next.rvalid = 1'b0;
    end
  end

  // ***************************************************************
  // State register
  // ***************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cur_reg <= '0;
      cur_reg.st <= ST_NORMAL;
      cur_reg.ctrl <= CTRL_RESET;
      cur_reg.drv.chg_en <= 1'b1;
      cur_reg.drv.dsg_en <= 1'b1;
    end else begin
      cur_reg <= cur_next;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  assign chg_en = cur_reg.drv.chg_en;
  assign dsg_en = cur_reg.drv.dsg_en;
  assign sense_pullup_en = cur_reg.drv.pullup_en;
  assign sense_pulldown_en = cur_reg.drv.pulldown_en;
  assign pwrdn_req = cur_reg.drv.pwrdn_req;
  assign s_axi_awready = !cur_reg.aw_got && !cur_reg.bvalid;
  assign s_axi_wready = !cur_reg.w_got && !cur_reg.bvalid;
  assign s_axi_bvalid = cur_reg.bvalid;
  assign s_axi_bresp = cur_reg.bresp;
  assign s_axi_arready = !cur_reg.rvalid;
  assign s_axi_rvalid = cur_reg.rvalid;
  assign s_axi_rdata = cur_reg.rdata;
  assign s_axi_rresp = cur_reg.rresp;

  // ***************************************************************
  // Assertions
  // ***************************************************************
  a_normal_both_on: assert property (
    @(posedge clk) disable iff (!rstn)
    (cur_reg.st == ST_NORMAL && !cur_reg.abn_chg && cur_reg.ctrl == 2'h0) |-> (chg_en && dsg_en))
    else $error("Normal state without both switches enabled");

  a_overchg_entry: assert property (
    @(posedge clk) disable iff (!rstn)
    $rose(cur_reg.st == ST_OVERCHG) |-> ($past(ovchg_done) && !chg_en))
    else $error("Overcharge entered without its delay");

  a_overdis_entry: assert property (
    @(posedge clk) disable iff (!rstn)
    ($rose(cur_reg.st == ST_OVERDIS) && $past(cur_reg.st) == ST_NORMAL) |-> ($past(ovdis_done) && !dsg_en))
    else $error("Overdischarge entered without its delay");

  a_overdis_pullup: assert property (
    @(posedge clk) disable iff (!rstn)
    (cur_reg.st inside {ST_OVERDIS, ST_PWRDN}) |-> (sense_pullup_en && !sense_pulldown_en && !dsg_en))
    else $error("Pull-up not applied in undervoltage states");

  a_sleep_entry: assert property (
    @(posedge clk) disable iff (!rstn)
    (cur_reg.st == ST_OVERDIS && cmp.sense_above_sleep && !cmp.temp_trip) |=> (pwrdn_req && !chg_en))
    else $error("Power-down not entered on high sense pin");

  a_ovcur_inhibit: assert property (
    @(posedge clk) disable iff (!rstn)
    (cur_reg.st == ST_NORMAL && cmp.cell_above_ovchg && !cmp.sense_ge_short) |=> (cur_reg.st != ST_OVERCUR))
    else $error("Overcurrent tripped while cell above overcharge level");

  a_overcur_pulldown: assert property (
    @(posedge clk) disable iff (!rstn)
    (cur_reg.st == ST_OVERCUR) |-> (sense_pulldown_en && !dsg_en && !sense_pullup_en))
    else $error("Pull-down not applied in overcurrent");

  a_overcur_release: assert property (
    @(posedge clk) disable iff (!rstn)
    (cur_reg.st == ST_OVERCUR && !cur_reg.short_trip && !cmp.sense_ge_overcur && !cmp.temp_trip && !ovdis_done)
    |=> (cur_reg.st == ST_NORMAL) ##0 !sense_pulldown_en)
    else $error("Overcurrent not released when sense pin fell");

  a_temp_all_off: assert property (
    @(posedge clk) disable iff (!rstn)
    cmp.temp_trip |=> (!chg_en && !dsg_en) [*2] or (!chg_en && !dsg_en ##1 !cmp.temp_trip))
    else $error("Switches not off on over-temperature");

  a_abn_clear: assert property (
    @(posedge clk) disable iff (!rstn)
    (cur_reg.abn_chg && !cmp.sense_below_charger && !abn_done) |=> !cur_reg.abn_chg)
    else $error("Abnormal charge flag not cleared");

endmodule // cps_core

// >>> core/cps_delay.sv
// Qualifying delay counter that restarts when its condition drops
`timescale 1ns/1ns
module cps_delay import cps_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Qualifier
  input wire logic run,
  input wire logic [CNT_W-1:0] limit,
  output logic done,
  output logic [CNT_W-1:0] count
);
  cps_delay_s dly_reg;
  cps_delay_s dly_next;

  always_comb begin
    dly_next = dly_reg;
    if (!run) begin
      dly_next.cnt = '0;
    end else if (dly_reg.cnt != limit) begin
      dly_next.cnt = dly_reg.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dly_reg <= '0;
    end else begin
      dly_reg <= dly_next;
    end
  end

  assign done = run && (dly_reg.cnt == limit);
  assign count = dly_reg.cnt;
endmodule // cps_delay

// >>> core/cps_pkg.sv
// Shared constants and types of the cell protection controller
package cps_pkg;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int CLK_MHZ = 100;
  localparam int OVERCHG_DELAY_MS = 130;
  localparam int OVERDIS_DELAY_MS = 40;
  localparam int OVERCUR_DELAY_MS = 10;
  localparam int SHORT_DELAY_US = 75;
  localparam int CNT_W = 24;
  localparam logic [CNT_W-1:0] OVERCHG_DELAY_CYC = CNT_W'(OVERCHG_DELAY_MS * 1000 * CLK_MHZ);
  localparam logic [CNT_W-1:0] OVERDIS_DELAY_CYC = CNT_W'(OVERDIS_DELAY_MS * 1000 * CLK_MHZ);
  localparam logic [CNT_W-1:0] OVERCUR_DELAY_CYC = CNT_W'(OVERCUR_DELAY_MS * 1000 * CLK_MHZ);
  localparam logic [CNT_W-1:0] SHORT_DELAY_CYC = CNT_W'(SHORT_DELAY_US * CLK_MHZ);
  // Recovery point of the die temperature comparator, in degrees
  localparam int THERMAL_RECOVERY_C = 100;

  // ***************************************************************
  // Register map
  // ***************************************************************
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h04;
  localparam logic [ADDR_W-1:0] CMP_OFFSET = 8'h08;
  localparam int CTRL_CHG_BLOCK_BIT = 0;
  localparam int CTRL_DSG_BLOCK_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_CHG_EN_BIT = 4;
  localparam int STAT_DSG_EN_BIT = 5;
  localparam int STAT_PULLUP_BIT = 6;
  localparam int STAT_PULLDOWN_BIT = 7;
  localparam int STAT_PWRDN_BIT = 8;
  localparam int STAT_ABN_BIT = 9;
  localparam int STAT_SHORT_BIT = 10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ***************************************************************
  // Types
  // ***************************************************************
  typedef enum logic [2:0] {
    ST_NORMAL = 3'h0,
    ST_OVERCHG = 3'h1,
    ST_OVERDIS = 3'h2,
    ST_PWRDN = 3'h3,
    ST_OVERCUR = 3'h4,
    ST_OVERTEMP = 3'h5
  } cps_state_e;

  typedef struct packed {
    logic cell_above_ovchg;
    logic cell_below_ovchg_rel;
    logic cell_below_ovdis;
    logic cell_above_ovdis_rel;
    logic cell_zero_chg;
    logic sense_disch_start;
    logic sense_ge_overcur;
    logic sense_ge_short;
    logic sense_above_sleep;
    logic supply_sense_wake;
    logic sense_below_charger;
    logic temp_trip;
    logic temp_recovered;
  } cps_cmp_s;

  localparam int CMP_W = $bits(cps_cmp_s);

  typedef struct packed {
    logic chg_en;
    logic dsg_en;
    logic pullup_en;
    logic pulldown_en;
    logic pwrdn_req;
  } cps_drive_s;

  typedef struct packed {
    cps_cmp_s s1;
    cps_cmp_s s2;
  } cps_sync_s;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } cps_delay_s;

  typedef struct packed {
    cps_state_e st;
    logic abn_chg;
    logic short_trip;
    cps_drive_s drv;
    logic [1:0] ctrl;
    logic aw_got;
    logic [ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } cps_core_s;

endpackage

// >>> core/cps_sync.sv
// Two-stage synchroniser for the comparator inputs
`timescale 1ns/1ns
module cps_sync import cps_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Comparator levels
  input wire cps_cmp_s cmp_async,
  output cps_cmp_s cmp_sync
);
  cps_sync_s sync_reg;
  cps_sync_s sync_next;

  always_comb begin
    sync_next = sync_reg;
    sync_next.s1 = cmp_async;
    sync_next.s2 = sync_reg.s1;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign cmp_sync = sync_reg.s2;
endmodule // cps_sync

// >>> verif/cps_cell_model.sv
// Behavioural cell, charger and load as seen through the device comparators
`timescale 1ns/1ns
module cps_cell_model import cps_pkg::*; #(
  parameter int OVCHG_MV = 4250,
  parameter int OVCHG_REL_MV = 4100,
  parameter int OVDIS_MV = 2900,
  parameter int OVDIS_REL_MV = 3000,
  parameter int ZERO_MV = 1800,
  parameter int DISCH_MV = 700,
  parameter int OVERCUR_MV = 1000,
  parameter int SHORT_MV = 1500,
  parameter int SLEEP_MV = 1500,
  parameter int WAKE_MV = 1300,
  parameter int CHARGER_MV = -120,
  parameter int TRIP_C = 120,
  parameter int RECOVER_C = 100
) (
  // Cell voltage, sense pin voltage (mV) and die temperature
  input wire logic signed [15:0] cell_mv,
  input wire logic signed [15:0] sense_mv,
  input wire logic signed [15:0] temp_c,
  // Comparator results
  output cps_cmp_s cmp
);
  // ***************************************************************
  // Comparators
  // ***************************************************************
  // Ideal comparators: no hysteresis, so the bench alone decides every edge
  always_comb begin
    int c;
    int s;
    int t;
    c = int'(cell_mv);
    s = int'(sense_mv);
    t = int'(temp_c);
    cmp.cell_above_ovchg = c > OVCHG_MV;
    cmp.cell_below_ovchg_rel = c < OVCHG_REL_MV;
    cmp.cell_below_ovdis = c < OVDIS_MV;
    cmp.cell_above_ovdis_rel = c >= OVDIS_REL_MV;
    cmp.cell_zero_chg = c <= ZERO_MV;
    cmp.sense_disch_start = s >= DISCH_MV;
    cmp.sense_ge_overcur = s >= OVERCUR_MV;
    cmp.sense_ge_short = s >= SHORT_MV;
    cmp.sense_above_sleep = s > SLEEP_MV;
    cmp.supply_sense_wake = (c - s) >= WAKE_MV;
    cmp.sense_below_charger = s < CHARGER_MV;
    cmp.temp_trip = t >= TRIP_C;
    cmp.temp_recovered = t <= RECOVER_C;
  end
endmodule // cps_cell_model

// >>> verif/tb_top.sv
// Self-checking bench for the cell protection controller
`timescale 1ns/1ns
module tb_top import cps_pkg::*;;
  // ***************************************************************
  // Signals
  // ***************************************************************
  localparam logic [4:0] NORM = 5'h18;
  localparam logic [31:0] STAT_IDLE = (32'h1 << STAT_CHG_EN_BIT) | (32'h1 << STAT_DSG_EN_BIT);
  logic clk, rstn;
  logic signed [15:0] cell_mv, sense_mv, temp_c;
  cps_cmp_s cmp_in;
  logic chg_en, dsg_en, sense_pullup_en, sense_pulldown_en, pwrdn_req;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp;
  int mismatches, cmp_count;

  // Short delays keep the run brief; undervoltage outlasts the abnormal charge delay so zero-volt priority shows
  cps_core #(.OVERCHG_CYC(24'h28), .OVERDIS_CYC(24'h32), .OVERCUR_CYC(24'h14), .SHORT_CYC(24'h05)) cps_core_inst (
    .clk(clk), .rstn(rstn), .cmp_in(cmp_in), .chg_en(chg_en), .dsg_en(dsg_en),
    .sense_pullup_en(sense_pullup_en), .sense_pulldown_en(sense_pulldown_en), .pwrdn_req(pwrdn_req),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  cps_cell_model cps_cell_model_inst (.cell_mv(cell_mv), .sense_mv(sense_mv), .temp_c(temp_c), .cmp(cmp_in));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ***************************************************************
  // Tasks
  // ***************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic drive(input int c, input int s, input int t);
    cell_mv <= 16'(c);
    sense_mv <= 16'(s);
    temp_c <= 16'(t);
  endtask
  // Switch outputs packed as charge, discharge, pull-up, pull-down, power-down
  task automatic outs_after(input int n, input logic [4:0] exp, input string msg);
    tick(n);
    check({27'h0, chg_en, dsg_en, sense_pullup_en, sense_pulldown_en, pwrdn_req}, {27'h0, exp}, msg);
  endtask
  task automatic do_reset();
    rstn <= 1'b0;
    drive(3700, 0, 25);
    tick(2);
    rstn <= 1'b1;
  endtask
  // Ready signals stay high, so each wait ends on the answer edge
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && n < 100);
    check(32'(n < 100), 32'h1, "write answer");
    r = bresp;
  endtask
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && n < 100);
    check(32'(n < 100), 32'h1, "read answer");
    d = rdata;
    r = rresp;
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #200000;
    mismatches++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    report_and_stop();
  end

  // ***************************************************************
  // Tests
  // ***************************************************************
  initial begin
    mismatches = 0;
    cmp_count = 0;
    rstn = 1'b0;
    cell_mv = 16'sh0e74;
    sense_mv = 16'sh0000;
    temp_c = 16'sh0019;
    {awaddr, araddr, wdata, wstrb, awvalid, wvalid, arvalid} = '0;
    bready = 1'b1;
    rready = 1'b1;
    tick(2);
    rstn <= 1'b1;
    outs_after(1, NORM, "reset outputs");
    axi_read(STATUS_OFFSET, rd, rsp);
    check(rd, STAT_IDLE, "status after reset");
    axi_read(CMP_OFFSET, rd, rsp);
    check(rd, 32'(cmp_in), "comparator view");
    axi_write(CTRL_OFFSET, 32'h3, rsp);
    check(32'(rsp), 32'(RESP_OKAY), "ctrl write");
    outs_after(3, 5'h00, "software block");
    axi_read(CTRL_OFFSET, rd, rsp);
    check(rd, 32'h3, "ctrl readback");
    axi_write(CTRL_OFFSET, 32'h0, rsp);
    axi_write(8'h10, 32'h3, rsp);
    check(32'(rsp), 32'(RESP_DECERR), "unmapped write");
    axi_read(8'h10, rd, rsp);
    check({rd[29:0], rsp}, 32'(RESP_DECERR), "unmapped read");
    axi_write(STATUS_OFFSET, 32'hffff, rsp);
    axi_read(STATUS_OFFSET, rd, rsp);
    check(rd, STAT_IDLE, "status read only");
    $display("test registers done");

    drive(4300, 0, 25);
    outs_after(30, NORM, "overcharge early");
    drive(4000, 0, 25);
    tick(3);
    drive(4300, 0, 25);
    outs_after(37, NORM, "overcharge restart");
    outs_after(12, 5'h08, "overcharge trip");
    axi_read(STATUS_OFFSET, rd, rsp);
    check(32'(rd[2:0]), 32'(ST_OVERCHG), "overcharge state");
    drive(4000, 0, 25);
    outs_after(8, NORM, "overcharge release");
    drive(4300, 0, 25);
    outs_after(48, 5'h08, "overcharge again");
    drive(4300, 700, 25);
    outs_after(10, 5'h08, "held while cell high");
    drive(4200, 1200, 25);
    outs_after(10, 5'h08, "held under overcurrent");
    drive(4200, 700, 25);
    outs_after(8, NORM, "discharge start release");
    $display("test overcharge done");

    drive(2800, 0, 25);
    outs_after(26, NORM, "undervoltage early");
    outs_after(32, 5'h14, "overdischarge");
    drive(2800, 1600, 25);
    outs_after(8, 5'h05, "power down");
    drive(2800, -200, 25);
    outs_after(8, 5'h14, "charger wake");
    drive(2950, -200, 25);
    outs_after(8, NORM, "charger release");
    outs_after(32, NORM, "abnormal charge early");
    outs_after(12, 5'h08, "abnormal charge");
    drive(2950, 0, 25);
    outs_after(8, NORM, "charger removed");
    drive(2800, 0, 25);
    outs_after(60, 5'h14, "overdischarge again");
    drive(2950, 0, 25);
    outs_after(10, 5'h14, "no charger held");
    drive(3100, 0, 25);
    outs_after(8, NORM, "release level");
    $display("test overdischarge done");

    drive(3700, 1200, 25);
    outs_after(16, NORM, "overcurrent early");
    outs_after(12, 5'h12, "overcurrent");
    drive(3700, 0, 25);
    outs_after(8, NORM, "overcurrent release");
    drive(3700, 2000, 25);
    outs_after(12, 5'h12, "short");
    drive(3700, 0, 25);
    outs_after(8, NORM, "short release");
    drive(4300, 1200, 25);
    outs_after(26, NORM, "overcurrent inhibited");
    drive(4300, 2000, 25);
    outs_after(11, 5'h12, "short with high cell");
    do_reset();
    outs_after(1, NORM, "second reset");
    drive(2800, 2800, 25);
    outs_after(12, 5'h12, "load short");
    outs_after(46, 5'h05, "power down from overcurrent");
    do_reset();
    $display("test overcurrent done");

    drive(3700, 0, 125);
    outs_after(6, 5'h00, "over temperature");
    drive(3700, 0, 110);
    outs_after(10, 5'h00, "still hot");
    drive(3700, 0, 100);
    outs_after(6, NORM, "recovered");
    drive(1500, -200, 25);
    outs_after(48, NORM, "zero volt no abnormal charge");
    outs_after(12, 5'h14, "zero volt charge");
    $display("test temperature and zero volt done");
    report_and_stop();
  end
endmodule // tb_top
